//--- inc/csc_cfg.svh
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// ==========================================================
// Address map of the programming space seen by this block
`define CSC_ADDR_SEL   5'h00
`define CSC_CHAN_LO    5'h03
`define CSC_CHAN_HI    5'h18

// ==========================================================
// Field layout of channel_select_control
`define CSC_EN_MSB     7
`define CSC_EN_LSB     4
`define CSC_RSV_BIT    3
`define CSC_MODE_MSB   2
`define CSC_MODE_LSB   1
`define CSC_ORDER_BIT  0

// ==========================================================
// Reset value: all channels on, two-wire mode, MSB first
`define CSC_SEL_RST    8'hF0
`define CSC_FMT_RST    3'h0
`define CSC_EN_ALL     4'hF
`define CSC_EN_NONE    4'h0

// ==========================================================
// Sizes
`define CSC_NUM_CH     4
`define CSC_AW         5
`define CSC_DW         32
`define CSC_REG_W      8

`endif

//--- inc/csc_pkg.sv
`include "csc_cfg.svh"

package csc_pkg;

  // ==========================================================
  // Serial port formats, in field encoding order 00..11
  typedef enum logic [1:0] {
    CSC_MODE_TWO_WIRE,
    CSC_MODE_THREE_WIRE,
    CSC_MODE_TWO_BIT,
    CSC_MODE_FOUR_BIT
  } csc_smode_t;

  // ==========================================================
  // One register access from the serial port engine
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`CSC_AW-1:0]     addr;
    logic [`CSC_DW-1:0]     data;
  } csc_req_t;

  // Port format that a running transfer is decoded with
  typedef struct packed {
    csc_smode_t             mode;
    logic                   lsb_first;
  } csc_fmt_t;

endpackage : csc_pkg

//--- rtl/csc_chan_mem.sv
`timescale 1ns/10ps
`include "csc_cfg.svh"

module csc_chan_mem #(
  parameter int NUM_CH = `CSC_NUM_CH,
  parameter int AW     = `CSC_AW,
  parameter int DW     = `CSC_DW
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [NUM_CH-1:0]         wr_en,
  input  wire logic [AW-1:0]             wr_addr,
  input  wire logic [DW-1:0]             wr_data,
  input  wire logic [$clog2(NUM_CH)-1:0] rd_ch,
  input  wire logic [AW-1:0]             rd_addr,
  output      logic [DW-1:0]             rd_data
);

  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [NUM_CH-1:0][DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]                        rd;
  } ccm_state_t;

  ccm_state_t st_q;
  ccm_state_t st_d;

  // ==========================================================
  // One word per channel per address; every enabled copy is written
  always_comb begin
    st_d    = st_q;
    st_d.rd = st_q.mem[rd_ch][rd_addr];
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_en[c]) begin
        st_d.mem[c][wr_addr] = wr_data;
      end
    end
  end

  // Storage clears on reset so a read of a never written word is defined
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd;

  // ==========================================================
  // Checks
  property p_mem_skip;
    @(posedge clk) disable iff (!rst_b)
      (wr_en[1] == 1'b0) |=> $stable(st_q.mem[1]);
  endproperty
  a_mem_skip: assert property (p_mem_skip)
    else $error("disabled channel copy changed");

endmodule : csc_chan_mem

//--- rtl/csc_top.sv
`timescale 1ns/10ps
`include "csc_cfg.svh"

// Functional notes
// - channel select control is one 8-bit register at address 0x00.
// - bits 7:4 enable one channel each; all four set after reset.
// - enable bits act as soon as the write completes, no update strobe.
// - shared channel addresses write only the copies of enabled channels.
// - bits 2:1 pick two-wire, three-wire, 2-bit or 4-bit serial format.
// - bit 0 picks bit order; 0 MSB first at reset, 1 LSB first.
module csc_top #(
  parameter int NUM_CH = `CSC_NUM_CH,
  parameter int AW     = `CSC_AW,
  parameter int DW     = `CSC_DW
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire csc_pkg::csc_req_t req,
  input  wire logic              xfer_start,
  output      logic [NUM_CH-1:0] chan_en,
  output      logic [NUM_CH-1:0] chan_wr,
  output      csc_pkg::csc_fmt_t fmt,
  output      logic              rd_valid,
  output      logic [DW-1:0]     rd_data
);

  localparam int CW = $clog2(NUM_CH);

  // ==========================================================
  // Helpers
  function automatic logic is_chan_addr(input logic [AW-1:0] a);
    is_chan_addr = (a >= `CSC_CHAN_LO) && (a <= `CSC_CHAN_HI);
  endfunction : is_chan_addr

  // Lowest enabled channel answers reads of the shared addresses
  function automatic logic [CW-1:0] low_ch(input logic [NUM_CH-1:0] m);
    low_ch = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        low_ch = CW'(i);
      end
    end
  endfunction : low_ch

  // Decode the stored byte into the format of a transfer
  function automatic csc_pkg::csc_fmt_t fmt_of(
    input logic [`CSC_REG_W-1:0] r);
    fmt_of.mode      = csc_pkg::csc_smode_t'(
                         r[`CSC_MODE_MSB:`CSC_MODE_LSB]);
    fmt_of.lsb_first = r[`CSC_ORDER_BIT];
  endfunction : fmt_of

  // ==========================================================
  // State
  typedef struct packed {
    logic [`CSC_REG_W-1:0] csc;
    csc_pkg::csc_fmt_t     fmt;
    logic [NUM_CH-1:0]     wr_stb;
    logic                  pend;
    logic                  pend_mem;
    logic [`CSC_REG_W-1:0] pend_reg;
    logic                  rd_vld;
    logic [DW-1:0]         rd_dat;
  } csc_state_t;

  csc_state_t          st_q;
  csc_state_t          st_d;
  logic                sel_wr;
  logic                chan_wr_hit;
  logic [NUM_CH-1:0]   mem_wr_en;
  logic [DW-1:0]       mem_rd_data;

  // ==========================================================
  // Request decode
  assign sel_wr      = req.wr && (req.addr == `CSC_ADDR_SEL);
  // Enables already in force steer the shared-address write
  assign chan_wr_hit = req.wr && is_chan_addr(req.addr);
  assign mem_wr_en   = chan_wr_hit ?
                       st_q.csc[`CSC_EN_MSB:`CSC_EN_LSB] :
                       `CSC_EN_NONE;

  // ==========================================================
  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.wr_stb = mem_wr_en;
    // Reserved bit 3 is held at zero whatever is written
    if (sel_wr) begin
      st_d.csc = req.data[`CSC_REG_W-1:0];
      st_d.csc[`CSC_RSV_BIT] = 1'b0;
    end
    // Format is sampled only at a transfer start. A write landing in
    // the same cycle belonged to the previous transfer, so use the new
    // value; the transfer that wrote it is never disturbed.
    if (xfer_start) begin
      st_d.fmt = fmt_of(st_d.csc);
    end
    // Two-stage read: memory word arrives one cycle after the request
    st_d.pend     = req.rd;
    st_d.pend_mem = req.rd && is_chan_addr(req.addr);
    st_d.pend_reg = (req.rd && (req.addr == `CSC_ADDR_SEL)) ?
                    st_q.csc : '0;
    st_d.rd_vld   = st_q.pend;
    if (st_q.pend) begin
      st_d.rd_dat = st_q.pend_mem ? mem_rd_data :
                    DW'(st_q.pend_reg);
    end
  end

  // Register bank; reset leaves every channel enabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= '0;
      st_q.csc <= `CSC_SEL_RST;
      // Plain constant matching the format fields of the reset byte
      st_q.fmt <= `CSC_FMT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Per-channel copies of the channel and profile registers
  csc_chan_mem #(
    .NUM_CH (NUM_CH),
    .AW     (AW),
    .DW     (DW)
  ) csc_chan_mem_i (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (mem_wr_en),
    .wr_addr (req.addr),
    .wr_data (req.data),
    .rd_ch   (low_ch(st_q.csc[`CSC_EN_MSB:`CSC_EN_LSB])),
    .rd_addr (req.addr),
    .rd_data (mem_rd_data)
  );

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign chan_en  = st_q.csc[`CSC_EN_MSB:`CSC_EN_LSB];
  assign chan_wr  = st_q.wr_stb;
  assign fmt      = st_q.fmt;
  assign rd_valid = st_q.rd_vld;
  assign rd_data  = st_q.rd_dat;

  // ==========================================================
  // Checks
  logic seen_q;

  // Marks the first clock after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  property p_sel_store;
    @(posedge clk) disable iff (!rst_b)
      sel_wr |=> (st_q.csc[`CSC_REG_W-1:`CSC_RSV_BIT+1] ==
                  $past(req.data[`CSC_REG_W-1:`CSC_RSV_BIT+1]))
                 && (st_q.csc[`CSC_RSV_BIT-1:0] ==
                     $past(req.data[`CSC_RSV_BIT-1:0]))
                 && !st_q.csc[`CSC_RSV_BIT];
  endproperty
  a_sel_store: assert property (p_sel_store)
    else $error("register did not store written byte");

  property p_rst_en;
    @(posedge clk) disable iff (!rst_b)
      !seen_q |-> (chan_en == `CSC_EN_ALL) && !fmt.lsb_first;
  endproperty
  a_rst_en: assert property (p_rst_en)
    else $error("reset state not all enabled MSB first");

  property p_en_now;
    @(posedge clk) disable iff (!rst_b)
      sel_wr |=> chan_en == $past(req.data[`CSC_EN_MSB:`CSC_EN_LSB]);
  endproperty
  a_en_now: assert property (p_en_now)
    else $error("enables not applied on the write");

  property p_steer;
    @(posedge clk) disable iff (!rst_b)
      chan_wr_hit |=> (chan_wr == $past(chan_en)) ##1 (chan_wr == '0
                      || $past(chan_wr_hit));
  endproperty
  a_steer: assert property (p_steer)
    else $error("channel write strobes not equal to enables");

  property p_mode;
    @(posedge clk) disable iff (!rst_b)
      (xfer_start && !sel_wr) |=>
        fmt.mode == $past(st_q.csc[`CSC_MODE_MSB:`CSC_MODE_LSB]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("transfer format not taken from mode field");

  property p_order;
    @(posedge clk) disable iff (!rst_b)
      (xfer_start && !sel_wr) |=>
        fmt.lsb_first == $past(st_q.csc[`CSC_ORDER_BIT]);
  endproperty
  a_order: assert property (p_order)
    else $error("bit order not taken from order bit");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      !xfer_start |=> $stable(fmt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("format changed inside a transfer");

  c_sel_wr:   cover property (@(posedge clk) disable iff (!rst_b)
                sel_wr ##[1:20] xfer_start);
  // Write landing in the very cycle a transfer starts
  c_same:     cover property (@(posedge clk) disable iff (!rst_b)
                sel_wr && xfer_start);
  c_partial:  cover property (@(posedge clk) disable iff (!rst_b)
                chan_wr_hit && chan_en == 4'h9);
  c_rd_chan:  cover property (@(posedge clk) disable iff (!rst_b)
                req.rd && is_chan_addr(req.addr) ##2 rd_valid);

endmodule : csc_top

//--- testbench/csc_host.sv
`timescale 1ns/10ps

// ==========================================================
// Host controller model: drives the register request bus
module csc_host (
  input  wire logic              clk,
  output      csc_pkg::csc_req_t req,
  output      logic              xfer_start
);

  // Idle bus at time zero
  initial begin
    req        = '0;
    xfer_start = 1'b0;
  end

  // One bus cycle: change just after an edge, hold through the next edge
  task automatic acc(input logic        w,
                     input logic        r,
                     input logic [4:0]  a,
                     input logic [31:0] d,
                     input logic        x);
    req.wr     = w;
    req.rd     = r;
    req.addr   = a;
    req.data   = d;
    xfer_start = x;
    @(posedge clk);
    #1;
  endtask : acc

  // Released lines show the inverse of the last value, so sampling
  // outside a strobe never sees a lucky leftover
  task automatic idle();
    acc(1'b0, 1'b0, ~req.addr, ~req.data, 1'b0);
  endtask : idle

endmodule : csc_host

//--- testbench/channel_select_register_bench.sv
`timescale 1ns/10ps
`include "csc_cfg.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end

// ==========================================================
// Bench top
module channel_select_register_bench;
  logic              clk;
  logic              rst_b;
  csc_pkg::csc_req_t req;
  logic              xfer_start;
  logic [3:0]        chan_en;
  logic [3:0]        chan_wr;
  logic [3:0]        last_en;
  logic [3:0]        last_wr;
  csc_pkg::csc_fmt_t fmt;
  logic              rd_valid;
  logic [31:0]       rd_data;
  logic [2:0]        pf;
  int                fails = 0;
  int                compares = 0;
  int                cycles = 0;

  csc_top csc_top_i (
    .clk        (clk),
    .rst_b      (rst_b),
    .req        (req),
    .xfer_start (xfer_start),
    .chan_en    (chan_en),
    .chan_wr    (chan_wr),
    .fmt        (fmt),
    .rd_valid   (rd_valid),
    .rd_data    (rd_data)
  );

  csc_host csc_host_i (
    .clk        (clk),
    .req        (req),
    .xfer_start (xfer_start)
  );

  // ==========================================================
  // Clock and hang guard; the whole run needs some 90 cycles
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Access tasks
  // Strobe outputs last one cycle, so catch them before going idle
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    csc_host_i.acc(1'b1, 1'b0, a, d, 1'b0);
    `CHK(rd_valid, 1'b0)
    last_en = chan_en;
    last_wr = chan_wr;
    csc_host_i.idle();
  endtask : wr

  // Read answer is due exactly one edge after the request is taken
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    csc_host_i.acc(1'b0, 1'b1, a, ~req.data, 1'b0);
    csc_host_i.idle();
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask : rd

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // ==========================================================
  // Test sequence
  initial begin
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    `CHK(chan_en, 4'hF)
    `CHK(fmt, 3'h0)
    rd(5'h00, 32'h000000F0);
    rd(5'h01, 32'h00000000);
    // Upper data bits must not leak into the byte register
    wr(5'h00, 32'hFFFFFF90);
    `CHK(last_en, 4'h9)
    `CHK(last_wr, 4'h0)
    `CHK(fmt, 3'h0)
    rd(5'h00, 32'h00000090);
    wr(5'h03, 32'hA5A50001);
    `CHK(last_wr, 4'h9)
    rd(5'h03, 32'hA5A50001);
    wr(5'h00, 32'h00000020);
    `CHK(last_en, 4'h2)
    wr(5'h18, 32'h00001234);
    `CHK(last_wr, 4'h2)
    rd(5'h18, 32'h00001234);
    wr(5'h00, 32'h00000000);
    wr(5'h03, 32'h0000BEEF);
    `CHK(last_wr, 4'h0)
    wr(5'h00, 32'h00000010);
    rd(5'h03, 32'hA5A50001);
    // Outside the map: no strobe and no change to the register
    wr(5'h19, 32'h000000FF);
    `CHK(last_wr, 4'h0)
    rd(5'h00, 32'h00000010);
    wr(5'h00, 32'h000000F8);
    rd(5'h00, 32'h000000F0);
    // Every format and bit order, applied only at the next transfer
    pf = 3'h0;
    for (int m = 0; m < 8; m++) begin
      wr(5'h00, {24'h0, 4'hF, 1'b0, m[2:0]});
      `CHK(fmt, pf)
      csc_host_i.acc(1'b0, 1'b0, ~req.addr, ~req.data, 1'b1);
      `CHK(fmt, m[2:0])
      pf = m[2:0];
    end
    // A write in the start cycle governs that new transfer
    csc_host_i.acc(1'b1, 1'b0, 5'h00, 32'h000000F3, 1'b1);
    `CHK(fmt, 3'h3)
    csc_host_i.idle();
    // Mid-run reset: enables, format and copies return to reset state
    wr(5'h00, 32'h00000007);
    `CHK(last_en, 4'h0)
    rst_b = 1'b0;
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    `CHK(chan_en, 4'hF)
    `CHK(fmt, 3'h0)
    rd(5'h00, 32'h000000F0);
    rd(5'h03, 32'h00000000);
    final_report();
  end

endmodule : channel_select_register_bench
